/* File: hw/cfa_defines.svh */
`ifndef CFA_DEFINES_SVH
`define CFA_DEFINES_SVH

// device register offsets and fields
`define CFA_CR_OFS 8'h70
`define CFA_TX_OFS 8'h71
`define CFA_RX_OFS 8'h73
`define CFA_CR_EN_BIT 7

// command codes
`define CFA_CMD_ENABLE 8'h74
`define CFA_CMD_STATUS 8'h3C
`define CFA_CMD_INIT 8'h47
`define CFA_CMD_WRITE 8'hC9
`define CFA_CMD_SETADDR 8'hB4
`define CFA_CMD_READ 8'hCA
`define CFA_CMD_DISABLE 8'h26
`define CFA_CMD_BYPASS 8'hFF

// operand and data layout
`define CFA_ENABLE_OP1 8'h08
`define CFA_WRITE_OP3 8'h01
`define CFA_READ_OP1 8'h10
`define CFA_READ_OP3 8'h01
`define CFA_SECTOR_USER 8'h40
`define CFA_OPS_IDX 3
`define CFA_DISABLE_LAST 2
`define CFA_DATA_IDX 4
`define CFA_SETADDR_LAST 7
`define CFA_PAGE_BYTES 16
`define CFA_STATUS_BYTES 4
`define CFA_BUSY_BYTE 2
`define CFA_BUSY_BIT 4
`define CFA_DUMMY_BYTE 8'hFF
`define CFA_IDX_MAX 6'h3F

// timing
`define CFA_CLK_MHZ 250
`define CFA_PROG_NS 200000
`define CFA_PROG_CYCLES (`CFA_PROG_NS * `CFA_CLK_MHZ / 1000)
`define CFA_SRAM_ERASE_NS 100000
`define CFA_ERASE_MAX_MS 45000
`define CFA_ERASE_MAX_CYCLES (64'd45000 * 64'd250000)

// host register offsets
`define CFA_H_CTRL 12'h000
`define CFA_H_PAGE 12'h004
`define CFA_H_STAT 12'h008
`define CFA_H_WDATA 12'h010
`define CFA_H_RDATA 12'h020

`endif

/* File: hw/cfa_pkg.sv */
package cfa_pkg;
  typedef enum logic [2:0] {
    CFA_OP_OPEN,
    CFA_OP_INIT,
    CFA_OP_WRITE,
    CFA_OP_SETADDR,
    CFA_OP_READ,
    CFA_OP_CLOSE,
    CFA_OP_STATUS,
    CFA_OP_BYPASS
  } cfa_op_t;

  typedef enum {
    CFA_H_IDLE,
    CFA_H_EN_ON,
    CFA_H_TX,
    CFA_H_RX,
    CFA_H_EN_OFF
  } cfa_hstate_t;

  typedef enum {
    CFA_R_ERASE,
    CFA_R_LOAD,
    CFA_R_RUN
  } cfa_rstate_t;
endpackage

/* File: hw/cfa_link_if.sv */
`timescale 1ns/100ps
interface cfa_link_if;
  logic cyc;
  logic we;
  logic [7:0] adr;
  logic [7:0] dat_w;
  logic [7:0] dat_r;
  logic ack;

  modport dev (input cyc, input we, input adr, input dat_w, output dat_r, output ack);
  modport host (output cyc, output we, output adr, output dat_w, input dat_r, input ack);
endinterface

/* File: hw/cfa_device.sv */
`timescale 1ns/100ps
`include "cfa_defines.svh"

// Functional notes
// - I2C host frames strings with start/stop
// - SPI host frames strings with chip select
// - host sets access enable around each string
// - array rewritable while device keeps running
// - refresh reloads array into configuration image
// - config sector shares command and data registers; here set-address ignores every sector but the user sector
// - page reads/writes, sector erase, no bytes
// - bytes in via transmit, out via receive
// - host enables, then polls busy or waits
// - status command returns four bytes with busy
// - init-address command sets page zero
// - page write takes exactly sixteen data bytes
// - page address advances after each write
// - host waits out busy after page write
// - set-address loads page from four data bytes
// - page read returns sixteen bytes
// - multi-page read starts with dummy page
// - host times out on maximum erase time
// - page programming lasts 0.2 ms
// - configuration image erase under 0.1 ms
module cfa_device
  import cfa_pkg::*;
#(
  parameter int PAGES = 16,
  parameter int PROG_CYCLES = `CFA_PROG_CYCLES
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // host side
  cfa_link_if.dev link,
  // user side
  input wire logic refresh_req,
  output logic [8*`CFA_PAGE_BYTES-1:0] config_image,
  output logic nv_busy,
  output logic if_enabled
);
  localparam int AW = $clog2(PAGES);

  logic [7:0] mem [PAGES*`CFA_PAGE_BYTES];

  function automatic logic [AW+3:0] byte_at(input logic [AW-1:0] page, input logic [3:0] off);
    byte_at = {page, off};
  endfunction

  logic cr_en;
  logic ack;
  logic [7:0] dat_r;
  logic [5:0] idx;
  logic [7:0] cmd;
  logic [7:0] op2;
  logic [7:0] sa_sector;
  logic [7:0] sa_hi;
  logic [AW-1:0] page;
  logic [3:0] rd_pos;
  logic [1:0] st_pos;
  logic rd_dummy;
  logic [31:0] prog_cnt;
  logic ref_s1;
  logic ref_s2;
  logic ref_d;
  cfa_rstate_t rstate;
  logic [3:0] load_pos;

  // link decode: one access at a time, answered one cycle later
  wire acc = link.cyc & ~ack;
  wire wr_cr = acc & link.we & (link.adr == `CFA_CR_OFS);
  wire wr_tx = acc & link.we & (link.adr == `CFA_TX_OFS) & cr_en;
  wire rd_rx = acc & ~link.we & (link.adr == `CFA_RX_OFS);
  wire [7:0] d = link.dat_w;
  wire [7:0] cmd_now = (idx == 6'h00) ? d : cmd;
  wire prog_busy = (prog_cnt != 32'h0);
  wire ref_busy = (rstate != CFA_R_RUN);
  wire busy = prog_busy | ref_busy;
  wire at_ops = wr_tx & (idx == `CFA_OPS_IDX);
  wire in_data = wr_tx & (idx >= `CFA_DATA_IDX) & if_enabled;
  wire [5:0] doff = idx - 6'(`CFA_DATA_IDX);
  wire do_wr = in_data & (cmd == `CFA_CMD_WRITE) & ~prog_busy
             & (doff < 6'(`CFA_PAGE_BYTES));
  wire wr_last = do_wr & (doff == 6'(`CFA_PAGE_BYTES - 1));
  wire do_sa = in_data & (cmd == `CFA_CMD_SETADDR) & (idx == `CFA_SETADDR_LAST);
  wire rd_cmd = (cmd == `CFA_CMD_READ);
  wire ref_rise = ref_s2 & ~ref_d;

  // status word: busy lives in the third byte sent
  wire [7:0] st_byte = (st_pos == 2'(`CFA_BUSY_BYTE)) ? (8'(busy) << `CFA_BUSY_BIT) : 8'h00;
  wire [7:0] rd_byte = rd_dummy ? `CFA_DUMMY_BYTE : mem[byte_at(page, rd_pos)];
  wire [7:0] rx_byte = rd_cmd ? rd_byte : st_byte;

  // bus answer and framing control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack <= 1'b0;
      dat_r <= 8'h00;
      cr_en <= 1'b0;
      idx <= 6'h00;
    end
    else
    begin
      ack <= acc;
      if (rd_rx)
        dat_r <= rx_byte;
      if (wr_cr)
      begin
        cr_en <= d[`CFA_CR_EN_BIT];
        idx <= 6'h00;
      end
      else if (wr_tx && idx != `CFA_IDX_MAX)
        idx <= idx + 6'h01;
    end
  end

  // command parser; set-address moves the page only for the user sector (CFA_SECTOR_USER), any other sector is ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd <= `CFA_CMD_BYPASS;
      op2 <= 8'h00;
      if_enabled <= 1'b0;
      page <= '0;
      sa_sector <= 8'h00;
      sa_hi <= 8'h00;
      rd_pos <= 4'h0;
      st_pos <= 2'h0;
      rd_dummy <= 1'b0;
    end
    else
    begin
      if (wr_tx && idx == 6'h00)
        cmd <= d;
      if (wr_tx && idx == 6'h02)
        op2 <= d;
      if (wr_tx && idx == `CFA_DISABLE_LAST && cmd == `CFA_CMD_DISABLE)
        if_enabled <= 1'b0;
      if (at_ops)
      begin
        rd_pos <= 4'h0;
        st_pos <= 2'h0;
        case (cmd_now)
          `CFA_CMD_ENABLE: if_enabled <= 1'b1;
          `CFA_CMD_INIT: if (if_enabled) page <= '0;
          `CFA_CMD_READ: rd_dummy <= ({op2[5:0], d} > 14'h0001);
          default: rd_dummy <= rd_dummy;
        endcase
      end
      if (in_data && cmd == `CFA_CMD_SETADDR && idx == `CFA_DATA_IDX)
        sa_sector <= d;
      if (in_data && cmd == `CFA_CMD_SETADDR && idx == `CFA_SETADDR_LAST - 1)
        sa_hi <= d;
      if (do_sa && sa_sector == `CFA_SECTOR_USER)
        page <= AW'({sa_hi, d});
      else if (wr_last)
        page <= page + AW'(1);
      else if (rd_rx && rd_cmd && rd_pos == 4'hF && !rd_dummy)
        page <= page + AW'(1);
      if (rd_rx && rd_cmd)
      begin
        rd_pos <= rd_pos + 4'h1;
        if (rd_pos == 4'hF)
          rd_dummy <= 1'b0;
      end
      if (rd_rx && !rd_cmd)
        st_pos <= st_pos + 2'h1;
    end
  end

  // page store: one byte per data write, up to sixteen per page write frame
  always_ff @(posedge pclk)
  begin
    if (do_wr)
      mem[byte_at(page, doff[3:0])] <= d;
  end

  // programming time keeps busy set after the sixteenth byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prog_cnt <= 32'h0;
    else if (wr_last)
      prog_cnt <= 32'(PROG_CYCLES);
    else if (prog_busy)
      prog_cnt <= prog_cnt - 32'h1;
  end

  // refresh request comes from outside the clock domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_d <= 1'b0;
    end
    else
    begin
      ref_s1 <= refresh_req;
      ref_s2 <= ref_s1;
      ref_d <= ref_s2;
    end
  end

  // image reload: erase takes one cycle, then page zero is copied in;
  // the reload also runs once after reset, like a power-up load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rstate <= CFA_R_ERASE;
      load_pos <= 4'h0;
      config_image <= '0;
      nv_busy <= 1'b1;
    end
    else
    begin
      nv_busy <= busy;
      case (rstate)
        CFA_R_ERASE:
        begin
          config_image <= '0;
          load_pos <= 4'h0;
          rstate <= CFA_R_LOAD;
        end
        CFA_R_LOAD:
        begin
          config_image[load_pos*8 +: 8] <= mem[byte_at('0, load_pos)];
          load_pos <= load_pos + 4'h1;
          if (load_pos == 4'hF)
            rstate <= CFA_R_RUN;
        end
        CFA_R_RUN:
          if (ref_rise)
            rstate <= CFA_R_ERASE;
        default: rstate <= CFA_R_RUN;
      endcase
    end
  end

  assign link.ack = ack;
  assign link.dat_r = dat_r;
endmodule

/* File: hw/cfa_host.sv */
`timescale 1ns/100ps
`include "cfa_defines.svh"

module cfa_host
  import cfa_pkg::*;
#(
  parameter longint POLL_TIMEOUT = `CFA_ERASE_MAX_CYCLES
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device side
  cfa_link_if.host link
);
  logic [127:0] wdata;
  logic [127:0] rdata;
  logic [7:0] page;
  cfa_op_t op;
  cfa_hstate_t hs;
  logic [5:0] bidx;
  logic cyc;
  logic we;
  logic [7:0] adr;
  logic [7:0] dat_w;
  logic [31:0] stw;
  logic timeout;
  logic [43:0] tmo;

  // command string for each frame, one byte at a time
  function automatic logic [7:0] seq_byte(input cfa_op_t o, input logic [5:0] i,
                                          input logic [7:0] pg, input logic [127:0] wd);
    seq_byte = 8'h00;
    case (o)
      CFA_OP_OPEN: seq_byte = (i == 6'h0) ? `CFA_CMD_ENABLE :
                              (i == 6'h1) ? `CFA_ENABLE_OP1 : 8'h00;
      CFA_OP_STATUS: seq_byte = (i == 6'h0) ? `CFA_CMD_STATUS : 8'h00;
      CFA_OP_INIT: seq_byte = (i == 6'h0) ? `CFA_CMD_INIT : 8'h00;
      CFA_OP_WRITE: seq_byte = (i == 6'h0) ? `CFA_CMD_WRITE :
                               (i == 6'h3) ? `CFA_WRITE_OP3 :
                               (i >= 6'h4) ? wd[(i - 6'h4)*8 +: 8] : 8'h00;
      CFA_OP_SETADDR: seq_byte = (i == 6'h0) ? `CFA_CMD_SETADDR :
                                 (i == 6'h4) ? `CFA_SECTOR_USER :
                                 (i == 6'h7) ? pg : 8'h00;
      CFA_OP_READ: seq_byte = (i == 6'h0) ? `CFA_CMD_READ :
                              (i == 6'h1) ? `CFA_READ_OP1 :
                              (i == 6'h3) ? `CFA_READ_OP3 : 8'h00;
      CFA_OP_CLOSE: seq_byte = (i == 6'h0) ? `CFA_CMD_DISABLE : 8'h00;
      default: seq_byte = `CFA_CMD_BYPASS;
    endcase
  endfunction

  function automatic logic [5:0] tx_len(input cfa_op_t o);
    case (o)
      CFA_OP_WRITE: tx_len = 6'd20;
      CFA_OP_SETADDR: tx_len = 6'd8;
      CFA_OP_CLOSE: tx_len = 6'd3;
      CFA_OP_BYPASS: tx_len = 6'd1;
      default: tx_len = 6'd4;
    endcase
  endfunction

  wire [5:0] rx_len = (op == CFA_OP_READ) ? 6'(`CFA_PAGE_BYTES) :
                      (op == CFA_OP_STATUS) ? 6'(`CFA_STATUS_BYTES) : 6'h00;
  wire done_acc = cyc & link.ack;
  wire dev_busy = stw[8*(`CFA_STATUS_BYTES-1-`CFA_BUSY_BYTE) + `CFA_BUSY_BIT];
  wire running = (hs != CFA_H_IDLE);

  // apb decode
  wire apb_acc = psel & penable & ~pready;
  // writes land at the completion edge, where the master sees pready high
  wire apb_wr = psel & penable & pready & pwrite;
  wire in_wd = (paddr >= `CFA_H_WDATA) & (paddr < `CFA_H_RDATA);
  wire in_rd = (paddr >= `CFA_H_RDATA) & (paddr < `CFA_H_RDATA + 12'h010);
  wire mapped = (paddr == `CFA_H_CTRL) | (paddr == `CFA_H_PAGE) | (paddr == `CFA_H_STAT)
              | ((in_wd | in_rd) & (paddr[1:0] == 2'b00));
  wire [1:0] wsel = paddr[3:2];
  wire start = apb_wr & (paddr == `CFA_H_CTRL) & ~running;
  wire [31:0] rd_mux = (paddr == `CFA_H_PAGE) ? {24'h0, page} :
                       (paddr == `CFA_H_STAT) ? {29'h0, timeout, dev_busy, running} :
                       in_wd ? wdata[wsel*32 +: 32] :
                       in_rd ? rdata[wsel*32 +: 32] : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      page <= 8'h00;
      wdata <= '0;
    end
    else
    begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~mapped;
      if (apb_acc)
        prdata <= pwrite ? 32'h0 : rd_mux;
      if (apb_wr && paddr == `CFA_H_PAGE)
        page <= pwdata[7:0];
      if (apb_wr && in_wd && !running)
        wdata[wsel*32 +: 32] <= pwdata;
    end
  end

  // frame engine: enable bit on, bytes out, bytes in, enable bit off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hs <= CFA_H_IDLE;
      op <= CFA_OP_BYPASS;
      bidx <= 6'h00;
      cyc <= 1'b0;
      we <= 1'b0;
      adr <= 8'h00;
      dat_w <= 8'h00;
      stw <= 32'h0;
      rdata <= '0;
      timeout <= 1'b0;
      tmo <= 44'h0;
    end
    else
    begin
      if (done_acc)
        cyc <= 1'b0;
      case (hs)
        CFA_H_IDLE:
          if (start)
          begin
            op <= cfa_op_t'(pwdata[2:0]);
            timeout <= 1'b0;
            tmo <= 44'h0;
            hs <= CFA_H_EN_ON;
          end
        CFA_H_EN_ON:
          if (!cyc)
          begin
            cyc <= 1'b1;
            we <= 1'b1;
            adr <= `CFA_CR_OFS;
            dat_w <= 8'h01 << `CFA_CR_EN_BIT;
          end
          else if (done_acc)
          begin
            bidx <= 6'h00;
            hs <= CFA_H_TX;
          end
        CFA_H_TX:
          if (!cyc)
          begin
            cyc <= 1'b1;
            we <= 1'b1;
            adr <= `CFA_TX_OFS;
            dat_w <= seq_byte(op, bidx, page, wdata);
          end
          else if (done_acc)
          begin
            bidx <= (bidx + 6'h01 == tx_len(op)) ? 6'h00 : bidx + 6'h01;
            if (bidx + 6'h01 == tx_len(op))
              hs <= (rx_len != 6'h00) ? CFA_H_RX : CFA_H_EN_OFF;
          end
        CFA_H_RX:
          if (!cyc)
          begin
            cyc <= 1'b1;
            we <= 1'b0;
            adr <= `CFA_RX_OFS;
          end
          else if (done_acc)
          begin
            if (op == CFA_OP_STATUS)
              stw <= {stw[23:0], link.dat_r};
            else
              rdata[bidx*8 +: 8] <= link.dat_r;
            bidx <= bidx + 6'h01;
            if (bidx + 6'h01 == rx_len)
              hs <= CFA_H_EN_OFF;
          end
        CFA_H_EN_OFF:
          if (!cyc)
          begin
            cyc <= 1'b1;
            we <= 1'b1;
            adr <= `CFA_CR_OFS;
            dat_w <= 8'h00;
          end
          else if (done_acc)
          begin
            hs <= CFA_H_EN_ON;
            case (op)
              CFA_OP_OPEN: op <= CFA_OP_STATUS;
              CFA_OP_WRITE: op <= CFA_OP_STATUS;
              CFA_OP_CLOSE: op <= CFA_OP_BYPASS;
              CFA_OP_STATUS:
                if (!dev_busy || timeout)
                  hs <= CFA_H_IDLE;
              default: hs <= CFA_H_IDLE;
            endcase
          end
        default: hs <= CFA_H_IDLE;
      endcase
      if (op == CFA_OP_STATUS && running && !timeout)
      begin
        tmo <= tmo + 44'h1;
        if (tmo >= 44'(POLL_TIMEOUT))
          timeout <= 1'b1;
      end
    end
  end

  assign link.cyc = cyc;
  assign link.we = we;
  assign link.adr = adr;
  assign link.dat_w = dat_w;
endmodule

/* File: tb/cfa_link_props.sv */
`timescale 1ns/100ps
module cfa_link_props
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link signals
  input wire logic cyc,
  input wire logic we,
  input wire logic [7:0] adr,
  input wire logic [7:0] dat_w,
  input wire logic [7:0] dat_r,
  input wire logic ack
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic en;
  logic sbusy;
  logic [4:0] cnt;
  logic [4:0] rcnt;
  logic [7:0] cmd;
  logic [7:0] prev;
  wire tx_w = ack && we && adr == 8'h71;
  wire rx_r = ack && !we && adr == 8'h73;
  wire ctl_w = ack && we && adr == 8'h70;
  // a frame ends when the enable bit is written low
  wire close = ctl_w && !dat_w[7];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en <= 1'h0;
      sbusy <= 1'h0;
      cnt <= 5'h00;
      rcnt <= 5'h00;
      cmd <= 8'hFF;
      prev <= 8'hFF;
    end
    else
    begin
      if (ctl_w)
        en <= dat_w[7];
      cnt <= close ? 5'h00 : cnt + 5'(tx_w);
      rcnt <= close ? 5'h00 : rcnt + 5'(rx_r);
      if (close)
        prev <= cmd;
      if (tx_w && cnt == 5'h00)
        cmd <= dat_w;
      if (rx_r && rcnt == 5'h02)
        sbusy <= dat_r[4];
    end
  end

  property p_ack_next;
    cyc && !ack |=> ack && cyc && $stable(adr) && $stable(we) && $stable(dat_w);
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("link access not answered next cycle");
  property p_release;
    ack |=> !ack && !cyc;
  endproperty
  a_release: assert property (p_release)
    else $error("link ack or request not released");
  property p_map;
    cyc |-> adr == 8'h70 || (adr == 8'h71 && we) || (adr == 8'h73 && !we);
  endproperty
  a_map: assert property (p_map)
    else $error("link access to wrong offset or direction");
  property p_framed;
    cyc && adr != 8'h70 |-> en;
  endproperty
  a_framed: assert property (p_framed)
    else $error("data access outside enable frame");
  property p_write_len;
    close && cmd == 8'hC9 |-> cnt == 5'h14 && rcnt == 5'h00;
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("page write frame not sixteen data bytes");
  property p_status_len;
    close && cmd == 8'h3C |-> cnt == 5'h04 && rcnt == 5'h04;
  endproperty
  a_status_len: assert property (p_status_len)
    else $error("status frame length wrong");
  property p_read_len;
    close && cmd == 8'hCA |-> cnt == 5'h04 && rcnt == 5'h10;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("page read frame length wrong");
  property p_addr_len;
    close && cmd == 8'hB4 |-> cnt == 5'h08;
  endproperty
  a_addr_len: assert property (p_addr_len)
    else $error("set address frame length wrong");
  property p_disable_len;
    close && cmd == 8'h26 |-> cnt == 5'h03 ##[1:20] (tx_w && dat_w == 8'hFF);
  endproperty
  a_disable_len: assert property (p_disable_len)
    else $error("disable frame wrong or no bypass after it");
  property p_poll;
    tx_w && cnt == 5'h00 && (prev == 8'hC9 || prev == 8'h74 || (prev == 8'h3C && sbusy))
      |-> dat_w == 8'h3C;
  endproperty
  a_poll: assert property (p_poll)
    else $error("busy not polled before next command");

  c_write: cover property (close && cmd == 8'hC9);
  c_read: cover property (close && cmd == 8'hCA);
  c_busy_poll: cover property (tx_w && cnt == 5'h00 && prev == 8'h3C && sbusy);
endmodule

/* File: tb/config_memory_command_access_tb.sv */
`timescale 1ns/100ps
`include "cfa_defines.svh"
module config_memory_command_access_tb;
  localparam int PRG = 20;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, sl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic refresh_req, nv_busy, if_enabled;
  logic [127:0] config_image, g, p0, p1, p2;
  int err_count;
  int comparisons;

  cfa_link_if cfa_link_if_i ();
  cfa_host #(.POLL_TIMEOUT(2000)) cfa_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(cfa_link_if_i.host));
  cfa_device #(.PAGES(16), .PROG_CYCLES(PRG)) cfa_device_i (.pclk(pclk), .presetn(presetn),
    .link(cfa_link_if_i.dev), .refresh_req(refresh_req), .config_image(config_image),
    .nv_busy(nv_busy), .if_enabled(if_enabled));
  cfa_link_props cfa_link_props_i (.pclk(pclk), .presetn(presetn), .cyc(cfa_link_if_i.cyc),
    .we(cfa_link_if_i.we), .adr(cfa_link_if_i.adr), .dat_w(cfa_link_if_i.dat_w),
    .dat_r(cfa_link_if_i.dat_r), .ack(cfa_link_if_i.ack));

  initial
  begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    sl = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask

  // status polling relies on the host poll timeout (POLL_TIMEOUT) to cut a stuck operation short
  task automatic idle;
    rd = 32'h1;
    while (rd[0] !== 1'h0)
      apb(1'h0, `CFA_H_STAT, 32'h0);
  endtask

  task automatic op(input logic [2:0] c);
    apb(1'h1, `CFA_H_CTRL, {29'h0, c});
    idle();
  endtask

  task automatic put_page(input logic [127:0] pg);
    for (int k = 0; k < 4; k++)
      apb(1'h1, `CFA_H_WDATA + 12'(4 * k), pg[32 * k +: 32]);
  endtask

  task automatic get_page(output logic [127:0] pg);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'h0, `CFA_H_RDATA + 12'(4 * k), 32'h0);
      pg[32 * k +: 32] = rd;
    end
  endtask

  function automatic logic [127:0] mk(input logic [7:0] base);
    for (int b = 0; b < 16; b++)
      mk[8 * b +: 8] = base + 8'(b);
  endfunction

  task automatic refresh(input logic [127:0] exp);
    int n;
    n = 0;
    refresh_req <= 1'h1;
    while (nv_busy !== 1'h1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    check(128'(n < 20), 128'h1, "reload never started");
    refresh_req <= 1'h0;
    n = 0;
    while (nv_busy !== 1'h0 && n < 25000)
    begin
      @(posedge pclk);
      n++;
    end
    check(128'(n < 25000), 128'h1, "reload too slow");
    check(config_image, exp, "reloaded image");
  endtask

  task automatic t_open;
    op(3'h0);
    check(128'(rd[2:0]), 128'h0, "status after open");
    check(128'(if_enabled), 128'h1, "interface not enabled");
    op(3'h6);
    check(128'(rd[2:1]), 128'h0, "standalone status poll");
    $display("open test done");
  endtask

  task automatic t_write;
    int n;
    op(3'h1);
    put_page(p0);
    apb(1'h1, `CFA_H_CTRL, 32'h2);
    n = 0;
    while (nv_busy !== 1'h1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    // busy must stand for exactly the programming time
    n = 0;
    while (nv_busy === 1'h1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    check(128'(n), 128'(PRG), "programming time");
    idle();
    check(128'(rd[2:1]), 128'h0, "busy or timeout after write");
    put_page(p1);
    apb(1'h1, `CFA_H_CTRL, 32'h2);
    // a close request while the write runs must be dropped
    op(3'h5);
    check(128'(if_enabled), 128'h1, "close taken while running");
    $display("write test done");
  endtask

  task automatic t_read;
    apb(1'h1, `CFA_H_PAGE, 32'h1);
    op(3'h3);
    op(3'h4);
    get_page(g);
    check(g, p1, "page one read");
    op(3'h1);
    op(3'h4);
    get_page(g);
    check(g, p0, "page zero read");
    op(3'h4);
    get_page(g);
    check(g, p1, "next page read");
    $display("read test done");
  endtask

  task automatic t_refresh;
    refresh(p0);
    put_page(p2);
    op(3'h1);
    op(3'h2);
    check(config_image, p0, "image changed before refresh");
    refresh(p2);
    $display("refresh test done");
  endtask

  task automatic t_close;
    op(3'h5);
    check(128'(if_enabled), 128'h0, "interface still enabled");
    apb(1'h0, 12'hFFC, 32'h0);
    check(128'(sl), 128'h1, "unmapped read not refused");
    apb(1'h0, 12'h002, 32'h0);
    check(128'(sl), 128'h1, "misaligned read not refused");
    apb(1'h0, `CFA_H_STAT, 32'h0);
    check(128'({sl, rd[0]}), 128'h0, "status read refused");
    $display("close test done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    test_done();
  end

  initial
  begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    refresh_req = 1'h0;
    presetn = 1'h0;
    err_count = 0;
    comparisons = 0;
    p0 = mk(8'h00);
    p1 = mk(8'h10);
    p2 = mk(8'hA0);
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (40) @(posedge pclk);
    check(128'(nv_busy), 128'h0, "power-up load not finished");
    t_open();
    t_write();
    t_read();
    t_refresh();
    t_close();
    test_done();
  end
endmodule
